// ---- src/sacr_sync.sv ----
`default_nettype none

// ************************************************************
// shared constants
// ************************************************************
package sacr_pkg;
	localparam int CH_NUM = 8;
	localparam int RES_W = 18;
	localparam int PAR_W = 16;
	localparam int SER_CH_PER_LINE = 4;
	localparam int CLK_MHZ = 250;
	// conversion time at oversampling off, in ns
	localparam int CONV_TIME_NS = 4000;
	// least time: round up to whole cycles
	localparam int CONV_CYC = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
	// highest usable oversampling code (ratio 64)
	localparam logic [2:0] OS_MAX = 3'h6;
	// first-channel flag in serial mode drops on this serial-clock fall
	localparam int SER_FLAG_FALLS = 18;
	// first-channel flag in parallel mode is high for these strobe falls
	localparam int PAR_FLAG_FIRST = 1;
	localparam int PAR_FLAG_LAST = 2;
	localparam logic [RES_W-1:0] RESULT_RST = 18'h00000;
	typedef enum logic {
		CONV_IDLE,
		CONV_RUN
	} sacr_conv_type;
endpackage : sacr_pkg

// ************************************************************
// two-flop synchroniser
// ************************************************************
module sacr_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_r <= '0;
			q_o <= '0;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule : sacr_sync

`default_nettype wire

// ---- src/sacr_top.sv ----
`default_nettype none

module sacr_top
	import sacr_pkg::*;
#(
	parameter int N_CH = CH_NUM,
	parameter int CONV_CYCLES = CONV_CYC,
	// 1: range high with standby gives shutdown; 0: range low gives shutdown
	parameter bit SHUTDOWN_ON_RANGE_HIGH = 1'b0
) (
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic RST_B_I,
	// host control pins
	input wire logic HOST_RESET_I,
	input wire logic CONV_START_A_I,
	input wire logic CONV_START_B_I,
	input wire logic INPUT_RANGE_SEL_I,
	input wire logic INTERFACE_SEL_I,
	input wire logic STANDBY_CTL_I,
	input wire logic [2:0] OVERSAMPLE_RATIO_SEL_I,
	// read link
	input wire logic CS_B_I,
	input wire logic RD_SCLK_I,
	// converter core
	input wire logic [N_CH*RES_W-1:0] CORE_RESULT_I,
	output logic HOLD_A_O,
	output logic HOLD_B_O,
	output logic RANGE_10V_O,
	output logic STANDBY_O,
	output logic SHUTDOWN_O,
	output logic [2:0] OS_RATIO_O,
	// status
	output logic BUSY_O,
	// parallel data
	output logic [PAR_W-1:0] PARALLEL_DATA_BUS_O,
	output logic PARALLEL_DATA_BUS_OE_O,
	// serial data
	output logic SERIAL_OUT_A_O,
	output logic SERIAL_OUT_B_O,
	output logic SERIAL_OUT_OE_O,
	// first channel marker
	output logic FIRST_CHANNEL_FLAG_O,
	output logic FIRST_CHANNEL_FLAG_OE_O
);
	localparam int CNT_W = 24;

	if (N_CH != CH_NUM) begin : g_bad_ch
		$error("sacr_top: channel count must be %0d", CH_NUM);
	end
	if (CONV_CYCLES < 1 ||
		(longint'(CONV_CYCLES) << OS_MAX) >= (longint'(1) << CNT_W)) begin : g_bad_cyc
		$error("sacr_top: CONV_CYCLES out of range");
	end

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [5:0] pin_raw;
	logic [5:0] pin_s;
	logic host_reset_s;
	logic conv_a_s;
	logic conv_b_s;
	logic range_s;
	logic ser_mode_s;
	logic standby_s;
	logic [2:0] os_s;

	assign pin_raw = {HOST_RESET_I, CONV_START_A_I, CONV_START_B_I,
		INPUT_RANGE_SEL_I, INTERFACE_SEL_I, STANDBY_CTL_I};

	sacr_sync #(.W(6)) u_sync_ctl (
		.clk_i(REF_CLK_I),
		.rst_b_i(RST_B_I),
		.d_i(pin_raw),
		.q_o(pin_s)
	);

	sacr_sync #(.W(3)) u_sync_os (
		.clk_i(REF_CLK_I),
		.rst_b_i(RST_B_I),
		.d_i(OVERSAMPLE_RATIO_SEL_I),
		.q_o(os_s)
	);

	assign host_reset_s = pin_s[5];
	assign conv_a_s = pin_s[4];
	assign conv_b_s = pin_s[3];
	assign range_s = pin_s[2];
	assign ser_mode_s = pin_s[1];
	assign standby_s = pin_s[0];

	// ************************************************************
	// edge detection
	// ************************************************************
	logic host_reset_d_r;
	logic conv_a_d_r;
	logic conv_b_d_r;
	logic [1:0] busy_hist_r;
	logic host_reset_rise;
	logic conv_a_rise;
	logic conv_b_rise;

	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			host_reset_d_r <= 1'b0;
			conv_a_d_r <= 1'b0;
			conv_b_d_r <= 1'b0;
			busy_hist_r <= 2'h0;
		end else begin
			host_reset_d_r <= host_reset_s;
			conv_a_d_r <= conv_a_s;
			conv_b_d_r <= conv_b_s;
			busy_hist_r <= {busy_hist_r[0], BUSY_O};
		end
	end

	assign host_reset_rise = host_reset_s & ~host_reset_d_r;
	// a pin rise made while busy stood high is dropped after the sync delay
	assign conv_a_rise = conv_a_s & ~conv_a_d_r & ~|busy_hist_r;
	assign conv_b_rise = conv_b_s & ~conv_b_d_r & ~|busy_hist_r;

	// ************************************************************
	// mode pins
	// ************************************************************
	logic shutdown_sel;

	assign shutdown_sel = (range_s == SHUTDOWN_ON_RANGE_HIGH);

	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			RANGE_10V_O <= 1'b0;
			STANDBY_O <= 1'b0;
			SHUTDOWN_O <= 1'b0;
			OS_RATIO_O <= 3'h0;
		end else begin
			RANGE_10V_O <= range_s;
			STANDBY_O <= standby_s & ~shutdown_sel;
			SHUTDOWN_O <= standby_s & shutdown_sel;
			OS_RATIO_O <= (os_s > OS_MAX) ? 3'h0 : os_s;
		end
	end

	// ************************************************************
	// conversion control
	// ************************************************************
	sacr_conv_type conv_state_r;
	logic seen_a_r;
	logic seen_b_r;
	logic [CNT_W-1:0] conv_cnt_r;
	logic [CNT_W-1:0] conv_len;
	logic start_conv;
	logic conv_done;

	// oversampling lengthens the conversion by the ratio
	assign conv_len = CNT_W'(CONV_CYCLES) << OS_RATIO_O;
	// both groups started, same-cycle edges included
	assign start_conv = (conv_state_r == CONV_IDLE) &
		(seen_a_r | conv_a_rise) & (seen_b_r | conv_b_rise);
	assign conv_done = (conv_state_r == CONV_RUN) & (conv_cnt_r == conv_len - 1'b1);

	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			conv_state_r <= CONV_IDLE;
		end else if (host_reset_rise) begin
			conv_state_r <= CONV_IDLE;
		end else begin
			case (conv_state_r)
				CONV_IDLE: begin
					if (start_conv)
						conv_state_r <= CONV_RUN;
				end
				CONV_RUN: begin
					if (conv_done)
						conv_state_r <= CONV_IDLE;
				end
				default: conv_state_r <= CONV_IDLE;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			conv_cnt_r <= '0;
		end else if (conv_state_r == CONV_RUN && !host_reset_rise && !conv_done) begin
			conv_cnt_r <= conv_cnt_r + 1'b1;
		end else begin
			conv_cnt_r <= '0;
		end
	end

	// start edges only count while idle; busy ignores them
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			seen_a_r <= 1'b0;
			seen_b_r <= 1'b0;
		end else if (host_reset_rise || start_conv) begin
			seen_a_r <= 1'b0;
			seen_b_r <= 1'b0;
		end else if (conv_state_r == CONV_IDLE) begin
			seen_a_r <= seen_a_r | conv_a_rise;
			seen_b_r <= seen_b_r | conv_b_rise;
		end
	end

	// track-and-hold per group; returns to track at end of conversion
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			HOLD_A_O <= 1'b0;
			HOLD_B_O <= 1'b0;
		end else if (host_reset_rise || conv_done) begin
			HOLD_A_O <= 1'b0;
			HOLD_B_O <= 1'b0;
		end else if (conv_state_r == CONV_IDLE) begin
			HOLD_A_O <= HOLD_A_O | conv_a_rise;
			HOLD_B_O <= HOLD_B_O | conv_b_rise;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			BUSY_O <= 1'b0;
		end else if (host_reset_rise || conv_done) begin
			BUSY_O <= 1'b0;
		end else if (start_conv) begin
			BUSY_O <= 1'b1;
		end
	end

	// ************************************************************
	// output data registers
	// ************************************************************
	logic [RES_W-1:0] result_r [N_CH];

	// stable between busy falls unless a host reset clears them; the host keeps reads off that edge
	generate
		for (genvar c = 0; c < N_CH; c++) begin : g_res
			always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
				if (!RST_B_I) begin
					result_r[c] <= RESULT_RST;
				end else if (host_reset_rise) begin
					result_r[c] <= RESULT_RST;
				end else if (conv_done) begin
					// two's complement codes kept as delivered
					result_r[c] <= CORE_RESULT_I[c*RES_W +: RES_W];
				end
			end
		end
	endgenerate

	// ************************************************************
	// read link domain
	// ************************************************************
	logic link_rst_b;
	logic [3:0] par_idx_r;
	logic [4:0] bit_cnt_r;
	logic [1:0] ser_ch_r;
	logic [4:0] fall_cnt_r;

	// the frame itself restarts the link logic while select is high
	assign link_rst_b = RST_B_I & ~CS_B_I;

	// parallel word index advances at the end of each strobe pulse
	always_ff @(posedge RD_SCLK_I or negedge link_rst_b) begin
		if (!link_rst_b)
			par_idx_r <= 4'h0;
		else
			par_idx_r <= par_idx_r + 4'h1;
	end

	// serial bit and channel counters
	always_ff @(posedge RD_SCLK_I or negedge link_rst_b) begin
		if (!link_rst_b) begin
			bit_cnt_r <= 5'h00;
			ser_ch_r <= 2'h0;
		end else if (bit_cnt_r == 5'(RES_W - 1)) begin
			bit_cnt_r <= 5'h00;
			ser_ch_r <= ser_ch_r + 2'h1;
		end else begin
			bit_cnt_r <= bit_cnt_r + 5'h01;
		end
	end

	// falling strobe edges since the frame began, saturating
	always_ff @(negedge RD_SCLK_I or negedge link_rst_b) begin
		if (!link_rst_b)
			fall_cnt_r <= 5'h00;
		else if (fall_cnt_r != 5'h1F)
			fall_cnt_r <= fall_cnt_r + 5'h01;
	end

	// ************************************************************
	// pin drivers
	// ************************************************************
	logic [2:0] par_ch;
	logic [RES_W-1:0] par_word;
	logic [4:0] ser_bit;
	logic [RES_W-1:0] ser_word_a;
	logic [RES_W-1:0] ser_word_b;

	assign par_ch = par_idx_r[3:1];
	assign par_word = result_r[par_ch];
	assign ser_bit = 5'(RES_W - 1) - bit_cnt_r;
	assign ser_word_a = result_r[{1'b0, ser_ch_r}];
	assign ser_word_b = result_r[{1'b1, ser_ch_r}];

	always_comb begin
		if (par_idx_r[0])
			PARALLEL_DATA_BUS_O = {par_word[1:0], 14'h0000};
		else
			PARALLEL_DATA_BUS_O = par_word[RES_W-1:2];
	end

	assign PARALLEL_DATA_BUS_OE_O = ~ser_mode_s & ~CS_B_I & ~RD_SCLK_I;
	assign SERIAL_OUT_OE_O = ser_mode_s & ~CS_B_I;
	// MSB stands from the select fall since the counter restarts at zero
	assign SERIAL_OUT_A_O = ser_word_a[ser_bit];
	assign SERIAL_OUT_B_O = ser_word_b[ser_bit];

	assign FIRST_CHANNEL_FLAG_OE_O = ~CS_B_I;
	always_comb begin
		if (ser_mode_s)
			FIRST_CHANNEL_FLAG_O = (fall_cnt_r < 5'(SER_FLAG_FALLS));
		else
			FIRST_CHANNEL_FLAG_O = (fall_cnt_r >= 5'(PAR_FLAG_FIRST)) &&
				(fall_cnt_r <= 5'(PAR_FLAG_LAST));
	end
endmodule : sacr_top

`default_nettype wire

// ---- testbench/sacr_checker.sv ----
`default_nettype none
// ********
// port checker
// ********
module sacr_checker
	import sacr_pkg::*;
#(
	parameter int CONV_CYCLES = CONV_CYC
) (
	// clock, reset and host pins
	input wire logic REF_CLK_I,
	input wire logic RST_B_I,
	input wire logic HOST_RESET_I,
	input wire logic CONV_START_A_I,
	input wire logic CONV_START_B_I,
	input wire logic INPUT_RANGE_SEL_I,
	input wire logic INTERFACE_SEL_I,
	input wire logic STANDBY_CTL_I,
	input wire logic [2:0] OVERSAMPLE_RATIO_SEL_I,
	input wire logic CS_B_I,
	input wire logic RD_SCLK_I,
	// watched outputs
	input wire logic HOLD_A_O,
	input wire logic HOLD_B_O,
	input wire logic RANGE_10V_O,
	input wire logic STANDBY_O,
	input wire logic SHUTDOWN_O,
	input wire logic [2:0] OS_RATIO_O,
	input wire logic BUSY_O,
	input wire logic PARALLEL_DATA_BUS_OE_O,
	input wire logic SERIAL_OUT_OE_O,
	input wire logic FIRST_CHANNEL_FLAG_OE_O
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt_r;
	logic abort_r;
	default clocking dc @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_B_I);
	sequence s_busy_up;
		$rose(BUSY_O);
	endsequence
	sequence s_busy_down;
		$fell(BUSY_O);
	endsequence
	// busy length and aborted runs
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			cnt_r <= 0;
		end else begin
			cnt_r <= BUSY_O ? cnt_r + 1 : 0;
		end
	end
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			abort_r <= 1'b1;
		end else begin
			abort_r <= HOST_RESET_I | (abort_r & BUSY_O);
		end
	end
	chk_range_sync: assert property (
		$stable(INPUT_RANGE_SEL_I)[*5] |-> RANGE_10V_O == INPUT_RANGE_SEL_I)
		else $error("range output wrong");
	chk_power_mode: assert property (
		$stable({STANDBY_CTL_I, INPUT_RANGE_SEL_I})[*5] |-> {STANDBY_O, SHUTDOWN_O} ==
		{STANDBY_CTL_I & INPUT_RANGE_SEL_I, STANDBY_CTL_I & !INPUT_RANGE_SEL_I})
		else $error("power-down mode wrong");
	chk_ratio_map: assert property (
		$stable(OVERSAMPLE_RATIO_SEL_I)[*5] |-> OS_RATIO_O ==
		((OVERSAMPLE_RATIO_SEL_I == 3'h7) ? 3'h0 : OVERSAMPLE_RATIO_SEL_I))
		else $error("ratio output wrong");
	chk_par_enable: assert property (
		$stable(INTERFACE_SEL_I)[*5] |-> PARALLEL_DATA_BUS_OE_O ==
		(!INTERFACE_SEL_I && !CS_B_I && !RD_SCLK_I))
		else $error("parallel enable wrong");
	chk_ser_enable: assert property (
		$stable(INTERFACE_SEL_I)[*5] |-> SERIAL_OUT_OE_O == (INTERFACE_SEL_I && !CS_B_I))
		else $error("serial enable wrong");
	chk_flag_enable: assert property (
		FIRST_CHANNEL_FLAG_OE_O == !CS_B_I)
		else $error("flag enable wrong");
	chk_busy_start: assert property (
		s_busy_up |-> HOLD_A_O && HOLD_B_O && $past(CONV_START_A_I, 3) && $past(CONV_START_B_I, 3))
		else $error("busy rose without both starts");
	chk_busy_length: assert property (
		s_busy_down ##0 !abort_r |-> cnt_r == (CONV_CYCLES << OS_RATIO_O) && !HOLD_A_O && !HOLD_B_O)
		else $error("busy length wrong");
	chk_no_retrigger: assert property (
		s_busy_down |-> !BUSY_O [*3])
		else $error("busy restarted at once");
	chk_reset_abort: assert property (
		$rose(HOST_RESET_I) && BUSY_O |-> ##[1:6] !BUSY_O)
		else $error("host reset did not abort");
endmodule : sacr_checker

bind sacr_top sacr_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.*);
`default_nettype wire

// ---- testbench/sacr_host.sv ----
`default_nettype none
// ********
// host reading side
// ********
module sacr_host
	import sacr_pkg::*;
(
	// link pins
	output logic cs_b_o,
	output logic sclk_o,
	// data pins
	input wire logic [PAR_W-1:0] bus_i,
	input wire logic bus_oe_i,
	input wire logic a_i,
	input wire logic b_i,
	input wire logic ser_oe_i,
	input wire logic flag_i,
	input wire logic flag_oe_i
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [PAR_W-1:0] pw [72];
	logic [71:0] sa, sb, fl;
	// released lines settle away from the driven value
	wire [PAR_W-1:0] bus_w = bus_oe_i ? bus_i : ~bus_i;
	initial begin
		cs_b_o = 1'b1;
		sclk_o = 1'b1;
	end
	// one frame; link clock idles high
	task automatic rd(input bit ser);
		cs_b_o = 1'b0;
		#6;
		for (int i = 0; i < (ser ? 72 : 16); i++) begin
			sclk_o = 1'b0;
			#6;
			pw[i] = bus_w;
			sa[i] = ser_oe_i ? a_i : ~a_i;
			sb[i] = ser_oe_i ? b_i : ~b_i;
			fl[i] = flag_oe_i ? flag_i : ~flag_i;
			sclk_o = 1'b1;
			#6;
		end
		cs_b_o = 1'b1;
	endtask : rd
endmodule : sacr_host
`default_nettype wire

// ---- testbench/tb_simultaneous_adc_conv_readout.sv ----
`default_nettype none
module tb_simultaneous_adc_conv_readout import sacr_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int NC = 10;
	logic clk = 1'b0, rst_b = 1'b0, hr = 1'b0, sa_st = 1'b0, sb_st = 1'b0;
	logic rng = 1'b0, ifs = 1'b0, stb = 1'b0;
	logic cs_b, sclk, busy, ha, hb, a, b, soe, fl, floe, poe, r10, sby, sdn;
	logic [2:0] os = 3'h0, osr;
	logic [CH_NUM*RES_W-1:0] core = '0, exp_r;
	logic [PAR_W-1:0] bus;
	logic [31:0] seed = 32'hBDCD;
	int miscompares = 0, compares = 0;
	always #2 clk = ~clk;
	sacr_top #(.CONV_CYCLES(NC)) dut (
		.REF_CLK_I(clk), .RST_B_I(rst_b), .HOST_RESET_I(hr), .CONV_START_A_I(sa_st),
		.CONV_START_B_I(sb_st), .INPUT_RANGE_SEL_I(rng), .INTERFACE_SEL_I(ifs),
		.STANDBY_CTL_I(stb), .OVERSAMPLE_RATIO_SEL_I(os), .CS_B_I(cs_b), .RD_SCLK_I(sclk),
		.CORE_RESULT_I(core), .HOLD_A_O(ha), .HOLD_B_O(hb), .RANGE_10V_O(r10),
		.STANDBY_O(sby), .SHUTDOWN_O(sdn), .OS_RATIO_O(osr), .BUSY_O(busy),
		.PARALLEL_DATA_BUS_O(bus), .PARALLEL_DATA_BUS_OE_O(poe), .SERIAL_OUT_A_O(a),
		.SERIAL_OUT_B_O(b), .SERIAL_OUT_OE_O(soe), .FIRST_CHANNEL_FLAG_O(fl),
		.FIRST_CHANNEL_FLAG_OE_O(floe));
	sacr_host host (.cs_b_o(cs_b), .sclk_o(sclk), .bus_i(bus), .bus_oe_i(poe), .a_i(a),
		.b_i(b), .ser_oe_i(soe), .flag_i(fl), .flag_oe_i(floe));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	function automatic logic [PAR_W-1:0] exp_par(input logic [RES_W-1:0] r, input bit lo);
		return lo ? {r[1:0], 14'h0000} : r[17:2];
	endfunction : exp_par
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rnd();
		for (int j = 0; j < 5; j++) begin
			seed = xs(seed);
			core = {core[111:0], seed};
		end
		step(6);
	endtask : rnd
	task automatic conv(input bit split, input bit abort_run);
		int n;
		n = 0;
		exp_r = abort_run ? '0 : core;
		sa_st = 1'b1;
		if (split) begin
			step(4);
			chk({busy, ha, hb}, 3'h2);
		end
		sb_st = 1'b1;
		while (busy !== 1'b1 && n < 20) begin
			step(1);
			n++;
		end
		chk({busy, ha, hb}, 3'h7);
		sa_st = 1'b0;
		sb_st = 1'b0;
		step(2);
		sa_st = 1'b1;
		sb_st = 1'b1;
		if (abort_run) begin
			hr = 1'b1;
			step(25);
			hr = 1'b0;
		end
		n = 0;
		while (busy !== 1'b0 && n < 400) begin
			step(1);
			n++;
		end
		// results must stay as latched at busy fall
		core = ~core;
		step(8);
		chk({busy, ha, hb}, 3'h0);
		sa_st = 1'b0;
		sb_st = 1'b0;
		step(2);
	endtask : conv
	task automatic rd_chk(input bit ser);
		logic [17:0] r;
		step(4);
		host.rd(ser);
		for (int i = 0; i < (ser ? 72 : 16); i++) begin
			r = exp_r[(i / 2) * RES_W +: RES_W];
			if (ser) begin
				chk({host.sa[i], host.sb[i], host.fl[i]}, {exp_r[(i / 18) * RES_W + 17 - i % 18],
					exp_r[(i / 18 + 4) * RES_W + 17 - i % 18], i < 17});
			end else begin
				chk({host.pw[i], host.fl[i]}, {exp_par(r, i[0]), i < 2});
			end
		end
	endtask : rd_chk
	task automatic final_report();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	initial begin
		step(2);
		rst_b = 1'b1;
		hr = 1'b1;
		step(25);
		hr = 1'b0;
		for (int i = 0; i < 32; i++) begin
			{rng, stb, os} = i[4:0];
			step(6);
			chk({r10, sby, sdn, osr},
				{rng, stb & rng, stb & ~rng, (os == 3'h7) ? 3'h0 : os});
		end
		{rng, stb, os} = 5'h00;
		rnd();
		conv(1'b1, 1'b0);
		rd_chk(1'b0);
		core = {4{18'h20000, 18'h1FFFF}};
		os = 3'h1;
		step(6);
		conv(1'b0, 1'b0);
		rd_chk(1'b0);
		os = 3'h0;
		ifs = 1'b1;
		rnd();
		conv(1'b0, 1'b0);
		rd_chk(1'b1);
		ifs = 1'b0;
		rnd();
		conv(1'b0, 1'b1);
		rd_chk(1'b0);
		final_report();
	end
	// whole run needs a few microseconds
	initial begin
		#20000;
		miscompares++;
		final_report();
	end
endmodule : tb_simultaneous_adc_conv_readout
`default_nettype wire
